// ===== src/fphc_pkg.sv
package fphc_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  // Current loop auto gain: bandwidth 0.03 of loop rate, 2*pi in 1/1000
  localparam int unsigned LOOP_HZ_DEF = 10_000;
  localparam int unsigned BW_PERMILLE = 30;
  localparam int unsigned TWO_PI_X1000 = 6283;
  localparam int unsigned GAIN_SHIFT = 10;
  localparam int unsigned BASE_MA_DEF = 11_000;

  // PI arithmetic scaling
  localparam int unsigned PI_P_SHIFT = 8;
  localparam int unsigned PI_I_SHIFT = 12;

  // Angles in IQ27, one electrical revolution is 1.0
  localparam logic [31:0] ALIGN_ANGLE = 32'h0000_0000;
  localparam logic [31:0] ANGLE_STEP_DEF = 32'h0005_B05B;
  localparam int unsigned ANGLE_FRAC_W = 27;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_TARGET = 8'h08;
  localparam logic [7:0] OFS_OUTER = 8'h0C;
  localparam logic [7:0] OFS_INNER = 8'h10;
  localparam logic [7:0] OFS_EFF = 8'h14;
  localparam logic [7:0] OFS_MOTOR = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_VOLT = 8'h20;
  localparam int unsigned TABLE_SEL_BIT = 6;

  // Startup calibration configuration fields
  localparam int unsigned CFG_RAMP_LSB = 26;
  localparam int unsigned CFG_RUN_LSB = 22;
  localparam int unsigned CFG_CAP_LSB = 17;
  localparam int unsigned CFG_ALIGN_LSB = 13;
  localparam int unsigned CFG_SRC_BIT = 1;
  localparam logic [31:0] CFG_WMASK = 32'h3FFF_E002;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [3:0] RAMP_NOLIMIT = 4'hF;

  // Control register fields
  localparam int unsigned CTRL_POWER_BIT = 0;
  localparam int unsigned CTRL_CAL_BIT = 1;
  localparam int unsigned CTRL_PP_LSB = 4;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_00F3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
  localparam int unsigned TARGET_W = 15;

  // Dwell per code in ms; align code Ch, undefined, reuses 4 s
  localparam logic [15:0][13:0] DWELL_MS = {
    14'h2710, 14'h1D4C, 14'h1388, 14'h0FA0, 14'h0BB8, 14'h07D0,
    14'h05DC, 14'h03E8, 14'h02EE, 14'h01F4, 14'h0190, 14'h012C,
    14'h00C8, 14'h0064, 14'h0032, 14'h000A};

  // Ramp per code in mA/s, which equals uA added per ms
  localparam logic [15:0][22:0] RAMP_UA_MS = {
    23'h000000, 23'h4C4B40, 23'h1E8480, 23'h0F4240, 23'h07A120,
    23'h03D090, 23'h030D40, 23'h0249F0, 23'h0186A0, 23'h00C350,
    23'h0061A8, 23'h003A98, 23'h002710, 23'h001388, 23'h0003E8,
    23'h000064};

  // Calibration current cap per code in tenths of a percent
  localparam logic [31:0][9:0] CAP_PCT10 = {
    10'h3E8, 10'h3B6, 10'h384, 10'h352, 10'h320, 10'h2EE, 10'h2BC,
    10'h258, 10'h226, 10'h1F4, 10'h1C2, 10'h190, 10'h15E, 10'h12C,
    10'h113, 10'h0FA, 10'h0E1, 10'h0C8, 10'h0B4, 10'h0AA, 10'h0A0,
    10'h096, 10'h08C, 10'h082, 10'h078, 10'h06E, 10'h064, 10'h05F,
    10'h05A, 10'h055, 10'h050, 10'h04B};

  // Default angle tables, index {reverse, hall}
  localparam logic [15:0][31:0] DEF_ANGLES = {
    32'h0000_0000, 32'h0555_5555, 32'h0000_0000, 32'h06AA_AAAB,
    32'h02AA_AAAB, 32'h0400_0000, 32'h0155_5555, 32'h0000_0000,
    32'h0000_0000, 32'h0400_0000, 32'h06AA_AAAB, 32'h0555_5555,
    32'h0155_5555, 32'h02AA_AAAB, 32'h0000_0000, 32'h0000_0000};

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b000,
    CAL_ALIGN = 3'b001,
    CAL_RUN_FWD = 3'b010,
    CAL_RUN_REV = 3'b011,
    CAL_DONE = 3'b100
  } fphc_cal_e;

  typedef struct packed {
    logic signed [15:0] speed_fb;
    logic signed [15:0] power_fb;
    logic signed [15:0] id_fb;
    logic signed [15:0] iq_fb;
    logic signed [15:0] motor_supply_voltage;
    logic signed [15:0] open_loop_current_cap;
    logic signed [15:0] general_current_cap;
  } fphc_fb_s;

  typedef struct packed {
    logic signed [15:0] vd;
    logic signed [15:0] vq;
    logic signed [15:0] iq_ref;
    logic [31:0] drive_angle;
    logic [31:0] cal_current_ua;
    logic signed [15:0] ol_limit;
  } fphc_cmd_s;

  typedef struct packed {
    logic signed [15:0] out;
    logic signed [15:0] integ;
    logic sat;
  } fphc_pi_s;

  typedef struct packed {
    logic [15:0][31:0] word;
    logic [31:0] ra;
    logic [31:0] rb;
  } fphc_mem_s;

  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] ctrl;
    logic [14:0] target;
    logic [31:0] outer_gain;
    logic [31:0] inner_gain;
    logic [31:0] motor;
    logic signed [15:0] spd_integ;
    logic signed [15:0] d_integ;
    logic signed [15:0] q_integ;
    logic signed [15:0] iq_ref;
    logic signed [15:0] vd;
    logic signed [15:0] vq;
    logic [2:0] sat;
    logic q_pend;
    logic wr_pend;
    logic [7:0] bus_addr;
    logic rd_mem;
    logic [31:0] rdata;
    fphc_cal_e cal;
    logic [15:0] ms_cnt;
    logic [13:0] ms_left;
    logic [31:0] cur_ua;
    logic [31:0] angle;
    logic [31:0] travel;
    logic [2:0] last_hall;
    logic [1:0] mem_pend;
    logic [3:0] mem_addr;
    logic [31:0] mem_val;
    logic [15:0] seen;
    logic signed [15:0] ol_limit;
    logic [31:0] drive_angle;
  } fphc_state_s;

  // One PI step; integrator frozen while clamped, zeroed while stopped
  function automatic fphc_pi_s pi_step(
    input logic signed [15:0] ref_v,
    input logic signed [15:0] fb_v,
    input logic signed [15:0] kp,
    input logic signed [15:0] ki,
    input logic signed [15:0] integ,
    input logic signed [15:0] lim,
    input logic run
  );
    logic signed [16:0] err;
    logic signed [33:0] pr;
    logic signed [33:0] ir;
    logic signed [34:0] sum;
    logic signed [34:0] ni;
    logic signed [34:0] hi;
    fphc_pi_s r;
    err = 17'(ref_v) - 17'(fb_v);
    pr = 34'(kp) * 34'(err);
    ir = 34'(ki) * 34'(err);
    hi = 35'(lim);
    sum = 35'(pr >>> PI_P_SHIFT) + 35'(integ);
    ni = 35'(integ) + 35'(ir >>> PI_I_SHIFT);
    r.sat = (sum > hi) || (sum < -hi);
    if (sum > hi) begin
      r.out = lim;
    end else if (sum < -hi) begin
      r.out = -lim;
    end else begin
      r.out = sum[15:0];
    end
    if (!run) begin
      r.integ = 16'sh0000;
    end else if (r.sat || ni > hi || ni < -hi) begin
      r.integ = integ;
    end else begin
      r.integ = ni[15:0];
    end
    return r;
  endfunction

endpackage

// ===== src/fphc_angle_mem.sv
`timescale 1ns/1ps
module fphc_angle_mem (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Write port
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [31:0] wr_data,
  // Registered read ports
  input wire logic [3:0] ra_addr,
  output logic [31:0] ra_data,
  input wire logic [3:0] rb_addr,
  output logic [31:0] rb_data
);

  fphc_pkg::fphc_mem_s m_reg;
  fphc_pkg::fphc_mem_s m_next;

  always_comb begin
    m_next = m_reg;
    m_next.ra = m_reg.word[ra_addr];
    m_next.rb = m_reg.word[rb_addr];
    if (wr_en) begin
      m_next.word[wr_addr] = wr_data;
    end
  end

  // Tables come up holding the default lookup values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m_reg <= {fphc_pkg::DEF_ANGLES, 64'h0};
    end else begin
      m_reg <= m_next;
    end
  end

  assign ra_data = m_reg.ra;
  assign rb_data = m_reg.rb;

endmodule

// ===== src/fphc_core.sv
// Operation
// - Power mode swaps the outer loop feedback, same outer gains.
// - Outer loop output is the torque current reference; clamped stops integral.
// - Flux and torque current loops share one gain pair.
// - Voltage commands limited to the measured supply voltage.
// - Flux loop runs first, its voltage tested for saturation.
// - Saturated current loop stops integrating.
// - Auto gains target bandwidth of 0.03 times loop rate.
// - Both user current gains zero: computed gains used and reported.
// - Any user current gain nonzero: user gains used and reported.
// - Forward and reverse IQ27 angle tables start from defaults.
// - Calibration first holds alignment angle for alignment dwell.
// - Step angle per dwell, one mechanical turn each way, averaging.
// - Hall transition angles written into forward and reverse tables.
// - Bits 29-26 set calibration current slew; code Fh no limit.
// - Bits 25-22 select step dwell, 10ms up to 10s.
// - Bits 21-17 cap calibration current, 7.5% to 100%.
// - Bits 16-13 set alignment dwell on the same time scale.
// - Bit 1 picks open-loop or general current cap.
// - Calibration starts only with its enable bit set.
// - Target is a percentage of full command scaled by 32768.
// - Nonzero target write with calibration enabled starts calibration.
// - Zero target write after completion returns to idle.
`timescale 1ns/1ps
module fphc_core #(
  parameter int unsigned CYC_PER_MS_P = fphc_pkg::CYC_PER_MS,
  parameter int unsigned LOOP_HZ = fphc_pkg::LOOP_HZ_DEF,
  parameter int unsigned BASE_MA = fphc_pkg::BASE_MA_DEF,
  parameter logic [31:0] ANGLE_STEP = fphc_pkg::ANGLE_STEP_DEF
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Loop tick, position sensing and feedback
  input wire logic foc_tick,
  input wire logic [2:0] hall,
  input wire logic reverse_dir,
  input fphc_pkg::fphc_fb_s fb,
  // Drive commands and calibration status
  output fphc_pkg::fphc_cmd_s cmd,
  output logic cal_active,
  output logic cal_done
);

  localparam int unsigned BW_RAD = LOOP_HZ * fphc_pkg::BW_PERMILLE
    * fphc_pkg::TWO_PI_X1000 / 1_000_000;

  fphc_pkg::fphc_state_s s_reg;
  fphc_pkg::fphc_state_s s_next;
  fphc_pkg::fphc_pi_s pi_o;
  fphc_pkg::fphc_pi_s pi_d;
  fphc_pkg::fphc_pi_s pi_q;

  logic addr_ok;
  logic auto_gain;
  logic [31:0] kp_auto;
  logic [31:0] ki_auto;
  logic [31:0] eff_gain;
  logic [31:0] rd_val;
  logic [31:0] mem_a_data;
  logic [31:0] mem_b_data;
  logic [3:0] mem_b_addr;
  logic mem_we;
  logic [31:0] mem_wdata;
  logic ms_pulse;
  logic step_end;
  logic tgt_wr;
  logic start_req;
  logic stop_req;
  logic run_loops;
  logic running_cal;
  logic [3:0] pp;
  logic [31:0] rev_span;
  logic [31:0] cap_ua;
  logic [31:0] cur_sum;
  logic [3:0] ramp_code;
  logic signed [15:0] outer_fb;

  // Zero-wait slave: reads are latched in the address phase
  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.rd_mem ? mem_a_data : s_reg.rdata;

  // Gain auto calculation from inductance and resistance
  assign auto_gain = (s_reg.inner_gain == 32'h0000_0000);
  assign kp_auto = (32'(s_reg.motor[31:16]) * 32'(BW_RAD))
    >> fphc_pkg::GAIN_SHIFT;
  assign ki_auto = (32'(s_reg.motor[15:0]) * 32'(BW_RAD))
    >> fphc_pkg::GAIN_SHIFT;
  assign eff_gain = auto_gain ? {ki_auto[15:0], kp_auto[15:0]}
    : s_reg.inner_gain;

  // Calibration timing and targets
  assign ms_pulse = (s_reg.ms_cnt == 16'(CYC_PER_MS_P - 1));
  assign step_end = ms_pulse && (s_reg.ms_left == 14'h0001);
  assign pp = (s_reg.ctrl[fphc_pkg::CTRL_PP_LSB +: 4] == 4'h0) ? 4'h1
    : s_reg.ctrl[fphc_pkg::CTRL_PP_LSB +: 4];
  assign rev_span = 32'(pp) << fphc_pkg::ANGLE_FRAC_W;
  assign cap_ua = 32'(fphc_pkg::CAP_PCT10[
    s_reg.cfg[fphc_pkg::CFG_CAP_LSB +: 5]]) * 32'(BASE_MA);
  assign ramp_code = s_reg.cfg[fphc_pkg::CFG_RAMP_LSB +: 4];
  assign cur_sum = s_reg.cur_ua
    + 32'(fphc_pkg::RAMP_UA_MS[ramp_code]);
  assign running_cal = (s_reg.cal == fphc_pkg::CAL_ALIGN)
    || (s_reg.cal == fphc_pkg::CAL_RUN_FWD)
    || (s_reg.cal == fphc_pkg::CAL_RUN_REV);

  // Target writes steer the calibration sequence
  assign tgt_wr = s_reg.wr_pend && (s_reg.bus_addr == fphc_pkg::OFS_TARGET);
  assign start_req = tgt_wr && (hwdata[14:0] != 15'h0000)
    && s_reg.ctrl[fphc_pkg::CTRL_CAL_BIT];
  assign stop_req = tgt_wr && (hwdata[14:0] == 15'h0000);

  // Loops
  assign run_loops = (s_reg.target != 15'h0000)
    && (s_reg.cal == fphc_pkg::CAL_IDLE);
  assign outer_fb = s_reg.ctrl[fphc_pkg::CTRL_POWER_BIT] ? fb.power_fb
    : fb.speed_fb;

  always_comb begin
    pi_o = fphc_pkg::pi_step({1'b0, s_reg.target}, outer_fb,
      s_reg.outer_gain[15:0], s_reg.outer_gain[31:16], s_reg.spd_integ,
      fb.general_current_cap, run_loops);
    pi_d = fphc_pkg::pi_step(16'sh0000, fb.id_fb, eff_gain[15:0],
      eff_gain[31:16], s_reg.d_integ, fb.motor_supply_voltage,
      run_loops);
    pi_q = fphc_pkg::pi_step(s_reg.iq_ref, fb.iq_fb, eff_gain[15:0],
      eff_gain[31:16], s_reg.q_integ, fb.motor_supply_voltage,
      run_loops);
  end

  // Table port B serves the averaging read, else the Hall lookup
  assign mem_b_addr = (s_reg.mem_pend == 2'b01) ? s_reg.mem_addr
    : {reverse_dir, hall};
  assign mem_we = (s_reg.mem_pend == 2'b10);
  assign mem_wdata = s_reg.seen[s_reg.mem_addr]
    ? ((mem_b_data + s_reg.mem_val) >> 1) : s_reg.mem_val;

  always_comb begin
    case (haddr[7:0])
      fphc_pkg::OFS_CFG: rd_val = s_reg.cfg;
      fphc_pkg::OFS_CTRL: rd_val = s_reg.ctrl;
      fphc_pkg::OFS_TARGET: rd_val = {17'h0_0000, s_reg.target};
      fphc_pkg::OFS_OUTER: rd_val = s_reg.outer_gain;
      fphc_pkg::OFS_INNER: rd_val = s_reg.inner_gain;
      fphc_pkg::OFS_EFF: rd_val = eff_gain;
      fphc_pkg::OFS_MOTOR: rd_val = s_reg.motor;
      fphc_pkg::OFS_STATUS: rd_val = {21'h00_0000, hall, 1'b0, s_reg.sat,
        1'b0, s_reg.cal};
      fphc_pkg::OFS_VOLT: rd_val = {s_reg.vq, s_reg.vd};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    // Bus address phase
    s_next.wr_pend = addr_ok && hwrite;
    if (addr_ok) begin
      s_next.bus_addr = haddr[7:0];
      s_next.rd_mem = !hwrite && haddr[fphc_pkg::TABLE_SEL_BIT];
      s_next.rdata = rd_val;
    end
    // Bus data phase
    if (s_reg.wr_pend) begin
      case (s_reg.bus_addr)
        fphc_pkg::OFS_CFG: s_next.cfg = hwdata & fphc_pkg::CFG_WMASK;
        fphc_pkg::OFS_CTRL: s_next.ctrl = hwdata & fphc_pkg::CTRL_WMASK;
        fphc_pkg::OFS_TARGET: s_next.target = hwdata[14:0];
        fphc_pkg::OFS_OUTER: s_next.outer_gain = hwdata;
        fphc_pkg::OFS_INNER: s_next.inner_gain = hwdata;
        fphc_pkg::OFS_MOTOR: s_next.motor = hwdata;
        default: ;
      endcase
    end
    // Outer and flux loops on the tick, torque loop one cycle later
    if (foc_tick) begin
      s_next.spd_integ = pi_o.integ;
      s_next.iq_ref = pi_o.out;
      s_next.vd = pi_d.out;
      s_next.d_integ = pi_d.integ;
      s_next.sat[1:0] = {pi_d.sat, pi_o.sat};
      s_next.q_pend = 1'b1;
    end else if (s_reg.q_pend) begin
      s_next.q_pend = 1'b0;
    end
    if (s_reg.q_pend) begin
      s_next.vq = pi_q.out;
      s_next.q_integ = pi_q.integ;
      s_next.sat[2] = pi_q.sat;
    end
    // Limit source
    s_next.ol_limit = s_reg.cfg[fphc_pkg::CFG_SRC_BIT]
      ? fb.general_current_cap : fb.open_loop_current_cap;
    // Averaged table write takes a read then a write cycle
    if (s_reg.mem_pend == 2'b01) begin
      s_next.mem_pend = 2'b10;
    end else if (s_reg.mem_pend == 2'b10) begin
      s_next.mem_pend = 2'b00;
      s_next.seen[s_reg.mem_addr] = 1'b1;
    end
    // Millisecond base and current ramp during calibration
    s_next.ms_cnt = (running_cal && !ms_pulse) ? s_reg.ms_cnt + 16'h0001
      : 16'h0000;
    if (running_cal && ms_pulse) begin
      s_next.ms_left = s_reg.ms_left - 14'h0001;
      if (ramp_code == fphc_pkg::RAMP_NOLIMIT || cur_sum > cap_ua) begin
        s_next.cur_ua = cap_ua;
      end else begin
        s_next.cur_ua = cur_sum;
      end
    end
    case (s_reg.cal)
      fphc_pkg::CAL_IDLE: begin
        if (start_req) begin
          s_next.cal = fphc_pkg::CAL_ALIGN;
          s_next.angle = fphc_pkg::ALIGN_ANGLE;
          s_next.cur_ua = 32'h0000_0000;
          s_next.seen = 16'h0000;
          s_next.ms_left = fphc_pkg::DWELL_MS[
            s_reg.cfg[fphc_pkg::CFG_ALIGN_LSB +: 4]];
        end
      end
      fphc_pkg::CAL_ALIGN: begin
        if (step_end) begin
          s_next.cal = fphc_pkg::CAL_RUN_FWD;
          s_next.travel = 32'h0000_0000;
          s_next.last_hall = hall;
          s_next.ms_left = fphc_pkg::DWELL_MS[
            s_reg.cfg[fphc_pkg::CFG_RUN_LSB +: 4]];
        end
      end
      fphc_pkg::CAL_RUN_FWD, fphc_pkg::CAL_RUN_REV: begin
        if (step_end) begin
          if (hall != s_reg.last_hall) begin
            s_next.mem_pend = 2'b01;
            s_next.mem_addr = {s_reg.cal == fphc_pkg::CAL_RUN_REV, hall};
            s_next.mem_val = {5'h00, s_reg.angle[26:0]};
            s_next.last_hall = hall;
          end
          s_next.angle = (s_reg.cal == fphc_pkg::CAL_RUN_FWD)
            ? s_reg.angle + ANGLE_STEP : s_reg.angle - ANGLE_STEP;
          s_next.travel = s_reg.travel + ANGLE_STEP;
          s_next.ms_left = fphc_pkg::DWELL_MS[
            s_reg.cfg[fphc_pkg::CFG_RUN_LSB +: 4]];
          if (s_reg.travel + ANGLE_STEP >= rev_span) begin
            s_next.travel = 32'h0000_0000;
            s_next.cal = (s_reg.cal == fphc_pkg::CAL_RUN_FWD)
              ? fphc_pkg::CAL_RUN_REV : fphc_pkg::CAL_DONE;
          end
        end
      end
      fphc_pkg::CAL_DONE: begin
        s_next.cur_ua = 32'h0000_0000;
        if (stop_req) begin
          s_next.cal = fphc_pkg::CAL_IDLE;
        end
      end
      default: s_next.cal = fphc_pkg::CAL_IDLE;
    endcase
    // Hall lookup lags the sensor by two cycles, harmless at loop rates
    s_next.drive_angle = running_cal ? s_reg.angle : mem_b_data;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.cfg <= fphc_pkg::CFG_RESET;
      s_reg.ctrl <= fphc_pkg::CTRL_RESET;
      s_reg.cal <= fphc_pkg::CAL_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  fphc_angle_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(mem_we),
    .wr_addr(s_reg.mem_addr),
    .wr_data(mem_wdata),
    .ra_addr(haddr[5:2]),
    .ra_data(mem_a_data),
    .rb_addr(mem_b_addr),
    .rb_data(mem_b_data)
  );

  assign cmd.vd = s_reg.vd;
  assign cmd.vq = s_reg.vq;
  assign cmd.iq_ref = s_reg.iq_ref;
  assign cmd.drive_angle = s_reg.drive_angle;
  assign cmd.cal_current_ua = s_reg.cur_ua;
  assign cmd.ol_limit = s_reg.ol_limit;
  assign cal_active = running_cal;
  assign cal_done = (s_reg.cal == fphc_pkg::CAL_DONE);

endmodule

// ===== test/fphc_motor_model.sv
`timescale 1ns/1ps
module fphc_motor_model (
  // Clock
  input wire logic hclk,
  // Drive from the block
  input fphc_pkg::fphc_cmd_s cmd,
  // Sensing back to the block
  output logic [2:0] hall,
  output fphc_pkg::fphc_fb_s fb
);
  localparam logic [5:0][2:0] HALL_CODE = {
    3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  logic [29:0] pos;
  // Sector of the electrical angle, six sectors of 60 degrees
  assign pos = 30'(cmd.drive_angle[26:0]) * 30'h6;
  initial hall = 3'h1;
  always @(posedge hclk) begin
    hall <= HALL_CODE[pos[29:27]];
  end
  // Stiff load: currents stay at zero, so loop outputs are predictable
  assign fb = '{
    speed_fb: 16'sh1000,
    power_fb: 16'sh0000,
    id_fb: 16'sh0000,
    iq_fb: 16'sh0000,
    motor_supply_voltage: 16'sh0400,
    open_loop_current_cap: 16'sh0111,
    general_current_cap: 16'sh2000};
endmodule

// ===== test/fphc_core_assertions.sv
`timescale 1ns/1ps
module fphc_core_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Loop and drive
  input wire logic foc_tick,
  input fphc_pkg::fphc_fb_s fb,
  input fphc_pkg::fphc_cmd_s cmd,
  input wire logic cal_active,
  input wire logic cal_done
);
  logic take;
  logic tgt_wr;
  logic cfg_wr;
  logic src_gen;
  assign take = hsel && htrans[1] && hready && hwrite;
  // Shadow of the limit source bit, updated in the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_wr <= 1'b0;
      cfg_wr <= 1'b0;
      src_gen <= 1'b0;
    end else begin
      tgt_wr <= take && haddr[7:0] == 8'h08;
      cfg_wr <= take && haddr[7:0] == 8'h00;
      if (cfg_wr) begin
        src_gen <= hwdata[1];
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_vd_clamp: assert property (
    cmd.vd <= fb.motor_supply_voltage && cmd.vd >= -fb.motor_supply_voltage)
    else $error("vd outside supply range");
  a_vq_clamp: assert property (
    cmd.vq <= fb.motor_supply_voltage && cmd.vq >= -fb.motor_supply_voltage)
    else $error("vq outside supply range");
  a_iq_clamp: assert property (
    cmd.iq_ref <= fb.general_current_cap
    && cmd.iq_ref >= -fb.general_current_cap)
    else $error("iq_ref outside current cap");
  a_vd_on_tick: assert property (
    $changed(cmd.vd) |-> $past(foc_tick))
    else $error("vd moved without a tick");
  a_vq_after_d: assert property (
    $changed(cmd.vq) |-> $past(foc_tick, 2))
    else $error("vq not one cycle after the flux loop");
  a_iq_on_tick: assert property (
    $changed(cmd.iq_ref) |-> $past(foc_tick))
    else $error("iq_ref moved without a tick");
  a_cal_start: assert property (
    $rose(cal_active) |-> $past(tgt_wr && hwdata[14:0] != 15'h0000))
    else $error("calibration began without a nonzero target");
  a_cal_idle: assert property (
    $fell(cal_done) |-> $past(tgt_wr && hwdata[14:0] == 15'h0000))
    else $error("done left without a zero target");
  a_cal_finish: assert property (
    $fell(cal_active) |-> cal_done)
    else $error("calibration stopped without completing");
  a_ol_source: assert property (
    $past(hresetn) |-> cmd.ol_limit == $past(src_gen ?
      fb.general_current_cap : fb.open_loop_current_cap))
    else $error("open loop limit from wrong source");
endmodule

bind fphc_core fphc_core_assertions i_fphc_core_assertions (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .foc_tick(foc_tick), .fb(fb), .cmd(cmd), .cal_active(cal_active),
  .cal_done(cal_done));

// ===== test/fphc_core_tb.sv
`timescale 1ns/1ps
module fphc_core_tb;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] r;
  } fphc_row_s;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] tgt;
    logic [15:0] iq;
    logic [15:0] vq;
  } fphc_loop_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic foc_tick = 1'b0;
  logic [2:0] tick_cnt = 3'h0;
  logic [2:0] hall;
  fphc_pkg::fphc_fb_s fb;
  fphc_pkg::fphc_cmd_s cmd;
  logic cal_active;
  logic cal_done;
  logic [31:0] rd;
  int fails = 0;
  int n_tests = 0;
  fphc_row_s rows [11] = '{
    '{8'h00, 32'hFFFF_FFFF, 32'h3FFF_E002},
    '{8'h00, 32'hC000_1FFD, 32'h0000_0000},
    '{8'h24, 32'h1234_5678, 32'h0000_0000},
    '{8'h18, 32'h0400_0800, 32'h0400_0800},
    '{8'h14, 32'hFFFF_FFFF, 32'h0EB8_075C},
    '{8'h10, 32'h0003_0005, 32'h0003_0005},
    '{8'h14, 32'h0000_0000, 32'h0003_0005},
    '{8'h10, 32'h0000_0000, 32'h0000_0000},
    '{8'h14, 32'h0000_0000, 32'h0EB8_075C},
    '{8'h0C, 32'h0000_0100, 32'h0000_0100},
    '{8'h10, 32'h0000_0100, 32'h0000_0100}};
  fphc_loop_s loops [4] = '{
    '{32'h11, 16'h0800, 16'h0800, 16'h0400},
    '{32'h10, 16'h0800, 16'hF800, 16'hFC00},
    '{32'h11, 16'h0300, 16'h0300, 16'h0300},
    '{32'h11, 16'h7FFF, 16'h2000, 16'h0400}};
  logic [7:0] cal_a [6] = '{8'h4C, 8'h58, 8'h50, 8'h6C, 8'h78, 8'h70};
  logic [31:0] cal_v [6] = '{32'h0200_0000, 32'h0400_0000, 32'h0600_0000,
    32'h0200_0000, 32'h0400_0000, 32'h0600_0000};

  always #12.5 hclk = ~hclk;
  always @(posedge hclk) begin
    tick_cnt <= tick_cnt + 3'h1;
    foc_tick <= tick_cnt == 3'h7;
  end

  fphc_core #(.CYC_PER_MS_P(4), .ANGLE_STEP(32'h0200_0000)) i_fphc_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .foc_tick(foc_tick), .hall(hall),
    .reverse_dir(1'b0), .fb(fb), .cmd(cmd), .cal_active(cal_active),
    .cal_done(cal_done));
  fphc_motor_model i_fphc_motor_model (
    .hclk(hclk), .cmd(cmd), .hall(hall), .fb(fb));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single transfer, then an idle cycle so a read sees a fresh write
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(posedge hclk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run needs about 700 cycles; allow over twenty times that
  initial begin
    repeat (15000) @(posedge hclk);
    fails++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, fphc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000_0010, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b0, fphc_pkg::OFS_CFG, 32'h0);
    chk("cfg reset", 32'h0, rd);
    for (int h = 0; h < 16; h++) begin
      bus(1'b0, 8'h40 + 8'(4 * h), 32'h0);
      chk("default table", fphc_pkg::DEF_ANGLES[h], rd);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 32'h0);
      chk("register", rows[i].r, rd);
    end
    $display("test registers done");
    foreach (loops[i]) begin
      bus(1'b1, fphc_pkg::OFS_CTRL, loops[i].ctrl);
      bus(1'b1, fphc_pkg::OFS_TARGET, {16'h0, loops[i].tgt});
      repeat (3) @(posedge foc_tick);
      repeat (2) @(posedge hclk);
      // Sample away from the edge that launches vq
      @(negedge hclk);
      chk("iq_ref", {16'h0, loops[i].iq}, {16'h0, cmd.iq_ref});
      chk("vq", {16'h0, loops[i].vq}, {16'h0, cmd.vq});
      chk("cal idle", 32'h0, {31'h0, cal_active});
    end
    bus(1'b0, fphc_pkg::OFS_STATUS, 32'h0);
    chk("sat flags", 32'h50, rd & 32'h70);
    bus(1'b0, fphc_pkg::OFS_VOLT, 32'h0);
    chk("voltages", 32'h0400_0000, rd);
    bus(1'b1, fphc_pkg::OFS_TARGET, 32'h0);
    $display("test loops done");
    bus(1'b1, fphc_pkg::OFS_CFG, 32'h3C3E_0000);
    bus(1'b1, fphc_pkg::OFS_CTRL, 32'h12);
    bus(1'b1, fphc_pkg::OFS_TARGET, 32'h1);
    chk("cal start", 32'h1, {31'h0, cal_active});
    repeat (60) @(posedge hclk);
    chk("align angle", 32'h0, cmd.drive_angle);
    chk("cal current", 32'd11000000, cmd.cal_current_ua);
    repeat (40) @(posedge hclk);
    chk("first step", 32'h0200_0000, cmd.drive_angle);
    for (int i = 0; i < 4000 && cal_done !== 1'b1; i++) @(posedge hclk);
    chk("cal done", 32'h1, {31'h0, cal_done});
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, cal_a[i], 32'h0);
      chk("cal table", cal_v[i], rd);
    end
    bus(1'b1, fphc_pkg::OFS_TARGET, 32'h0);
    chk("back to idle", 32'h0, {31'h0, cal_done});
    $display("test calibration done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h4C, 32'h0);
    chk("table after reset", fphc_pkg::DEF_ANGLES[3], rd);
    $display("test second reset done");
    stop_test();
  end
endmodule
